// [rtl/pib_bridge.sv]
`timescale 1ns/1ps
`include "pib_params.svh"

// Flush queue between the line buffer and the PCI master
module pib_fifo #(
  parameter int DW = 70,
  parameter int DEPTH = `PIB_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [DW-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [DW-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  // Storage plus one extra pointer bit to tell full from empty
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } pib_fifo_st_type;

  pib_fifo_st_type st_r, st_nxt;
  logic [AW:0] fill; // Words held

  assign fill = st_r.wp - st_r.rp;
  assign o_in_ready = fill != (AW+1)'(DEPTH);
  assign o_out_valid = fill != '0;
  assign o_out_data = st_r.mem[st_r.rp[AW-1:0]];

  // Pointer and storage update
  always_comb begin
    st_nxt = st_r;
    if (i_in_valid && o_in_ready) begin
      st_nxt.mem[st_r.wp[AW-1:0]] = i_in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (o_out_valid && i_out_ready) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= `PIB_RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // pib_fifo

// Function
// R01 - Undecoded ISA cycles stay on ISA
// R02 - Eight byte two way line buffer
// R03 - ISA I/O cycles skip the line buffer
// R04 - Separate ISA and DMA buffer mode bits
// R05 - Single mode write posts, later writes wait
// R06 - Single mode read fetches requested width only
// R07 - Line mode writes ping pong two halves
// R08 - PCI memory writes held in posted buffer
// R09 - Post only if empty, enabled, ISA free
// R10 - Full posted buffer retries new write
// R11 - Unposted write waits for ISA completion
// R12 - Unposted write with ISA busy is retried
// R13 - Reads and I/O skip posted buffer
// R14 - Write line flushes on four triggers
// R15 - Triggering ISA cycle waits for flush
// R16 - Acknowledge release flushes write line
// R17 - Pending flush retries all PCI cycles
// R18 - Accepted PCI write drops read line
// R19 - Read line dropped on miss or write
// R20 - Each byte read out is dropped
// R21 - Posted write retries later PCI cycles
// R22 - Posted buffer empty before ISA grant
// R23 - Flush byte enables follow valid bytes
module pib_bridge #(
  parameter int DACK_W = `PIB_DACK_W,
  parameter int FIFO_DEPTH = `PIB_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Configuration
  input wire logic i_mode_isa,
  input wire logic i_mode_dma,
  input wire logic i_post_en,
  // ISA master and DMA side
  input wire logic i_isa_req,
  input wire pib_pkg::pib_isa_req_type i_isa,
  output logic o_isa_ready,
  output logic [15:0] o_isa_rdata,
  input wire logic [DACK_W-1:0] i_dack_n,
  input wire logic i_isa_busy,
  input wire logic i_isa_owned,
  output logic o_grant_ok,
  // PCI master, line buffer write flushes
  output logic o_pm_valid,
  output pib_pkg::pib_xfer_type o_pm,
  input wire logic i_pm_ready,
  // PCI master, reads and I/O
  output logic o_dx_req,
  output pib_pkg::pib_xfer_type o_dx,
  input wire logic i_dx_ack,
  input wire logic [31:0] i_dx_rdata,
  // PCI slave side
  input wire logic i_ps_req,
  input wire pib_pkg::pib_ps_req_type i_ps,
  output logic o_ps_trdy,
  output logic o_ps_retry,
  output logic [31:0] o_ps_rdata,
  // ISA cycles on behalf of PCI masters
  output logic o_ic_req,
  output pib_pkg::pib_xfer_type o_ic,
  input wire logic i_ic_done,
  input wire logic [31:0] i_ic_rdata
);
  import pib_pkg::*;

  // All block state
  typedef struct packed {
    pib_lb_state_type lbs;
    logic wr;
    logic [7:0] valid;
    logic [63:0] data;
    logic [28:0] tag;
    logic one;
    logic fidx;
    logic isa_ack;
    logic [15:0] isa_rdata;
    logic [DACK_W-1:0] dack;
    logic dx_req;
    pib_xfer_type dx;
    logic pw_valid;
    logic ic_req;
    logic ic_posted;
    pib_xfer_type ic;
    logic trdy;
    logic retry;
    logic [31:0] ps_rdata;
  } pib_top_st_type;

  pib_top_st_type st_r, st_nxt;
  logic [1:0] rst_q; // Reset release chain
  logic rst_n; // Synchronised reset
  logic push_v; // Flush entry offered
  pib_xfer_type push_d; // Flush entry
  logic fifo_rdy; // Queue has room
  logic fifo_out_v; // Queue holds data
  logic lb_busy; // Flush scheduled or draining
  logic mode_line; // Mode of the current requester
  logic [7:0] msk; // Byte lanes of the ISA cycle
  logic hit_tag; // ISA cycle inside the line
  logic wr_held; // Line holds write data
  logic dack_drop; // Any acknowledge released
  logic ps_wacc; // PCI write accepted
  logic rd_hit; // Read served from the line
  logic [31:0] isa_d32; // ISA data on dword lanes
  logic [3:0] isa_be4; // ISA lanes in its dword

  // Byte lanes of a 16-bit ISA cycle within the line
  function automatic logic [7:0] lane_mask(input logic [2:0] a, input logic [1:0] be);
    lane_mask = {6'h00, be} << {a[2:1], 1'b0};
  endfunction

  // Widen a byte mask to a bit mask
  function automatic logic [63:0] bit_mask(input logic [7:0] m);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i*8 +: 8] = {8{m[i]}};
    end
    bit_mask = r;
  endfunction

  // One half of the line as a PCI write, lanes from valid bytes
  function automatic pib_xfer_type half_xfer(input logic [28:0] tag, input logic h,
                                             input logic [7:0] v, input logic [63:0] d);
    pib_xfer_type x;
    x.write = 1'b1;
    x.io = 1'b0;
    x.addr = {tag, h, 2'h0};
    x.be = h ? v[7:4] : v[3:0]; // R23
    x.data = h ? d[63:32] : d[31:0];
    half_xfer = x;
  endfunction

  // Reset is released through two flops
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Write data waits here so line mode half drains do not stall ISA; a flush holds ISA until PCI empties the queue
  pib_fifo #(
    .DW($bits(pib_xfer_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_in_valid(push_v),
    .o_in_ready(fifo_rdy),
    .i_in_data(push_d),
    .o_out_valid(fifo_out_v),
    .i_out_ready(i_pm_ready),
    .o_out_data(o_pm)
  );

  assign o_pm_valid = fifo_out_v;
  assign lb_busy = (st_r.lbs == LB_FLUSH) || fifo_out_v;
  assign mode_line = i_isa.dma ? i_mode_dma : i_mode_isa; // R04
  assign msk = lane_mask(i_isa.addr[2:0], i_isa.be);
  assign hit_tag = st_r.tag == i_isa.addr[31:`PIB_TAG_LSB];
  assign wr_held = st_r.wr && (st_r.valid != 8'h00);
  assign dack_drop = |(i_dack_n & ~st_r.dack);
  assign isa_be4 = i_isa.addr[`PIB_HALF_BIT] ? msk[7:4] : msk[3:0];
  assign isa_d32 = {16'h0000, i_isa.data} << {i_isa.addr[`PIB_LANE_LSB], 4'h0};

  // Next state for both buffers
  always_comb begin
    st_nxt = st_r;
    push_v = 1'b0;
    push_d = '0;
    ps_wacc = 1'b0;
    rd_hit = 1'b0;
    st_nxt.isa_ack = 1'b0;
    st_nxt.trdy = 1'b0;
    st_nxt.retry = 1'b0;
    st_nxt.dack = i_dack_n;
    // PCI slave side and posted buffer
    if (st_r.ic_req && i_ic_done) begin
      st_nxt.ic_req = 1'b0;
      if (st_r.ic_posted) begin
        st_nxt.pw_valid = 1'b0; // R21
      end else begin
        st_nxt.trdy = 1'b1; // R11
        st_nxt.ps_rdata = i_ic_rdata;
      end
    end else if (i_ps_req && (!st_r.ic_req || st_r.pw_valid) && !st_r.trdy && !st_r.retry) begin
      // Posted data in flight refuses every master; a forwarded cycle only waits on its own master
      if (lb_busy || st_r.pw_valid) begin
        st_nxt.retry = 1'b1; // R17 R10 R21
      end else if (i_ps.mem && i_ps.write && i_post_en && !i_isa_busy && !i_isa_owned) begin
        // Posted: accept now, ISA cycle follows at once
        st_nxt.pw_valid = 1'b1; // R08 R09 R22
        st_nxt.ic = {i_ps.write, !i_ps.mem, i_ps.addr, i_ps.be, i_ps.data};
        st_nxt.trdy = 1'b1;
        st_nxt.ic_req = 1'b1;
        st_nxt.ic_posted = 1'b1;
        ps_wacc = 1'b1;
      end else if (!i_isa_busy && !i_isa_owned) begin
        // Forwarded: answer only when ISA finishes
        st_nxt.ic_req = 1'b1; // R11 R13
        st_nxt.ic = {i_ps.write, !i_ps.mem, i_ps.addr, i_ps.be, i_ps.data};
        st_nxt.ic_posted = 1'b0;
        ps_wacc = i_ps.write;
      end else begin
        st_nxt.retry = 1'b1; // R12
      end
    end
    // Line buffer sequencer
    case (st_r.lbs)
      LB_IDLE: begin
        if (dack_drop && wr_held) begin
          st_nxt.lbs = LB_FLUSH; // R16
        end else if (wr_held && (st_r.valid[3:0] == 4'hF || st_r.valid[7:4] == 4'hF)) begin
          // Full half drains while the other half keeps filling
          push_v = 1'b1; // R07 R14
          push_d = half_xfer(st_r.tag, st_r.valid[3:0] != 4'hF, st_r.valid, st_r.data);
          if (fifo_rdy) begin
            if (st_r.valid[3:0] == 4'hF) begin
              st_nxt.valid[3:0] = 4'h0;
            end else begin
              st_nxt.valid[7:4] = 4'h0;
            end
          end
        end else if (i_isa_req && !st_r.isa_ack && i_isa.decoded) begin // R01
          if (!i_isa.mem) begin
            // I/O goes straight to PCI, buffer untouched
            st_nxt.lbs = LB_IO; // R03
            st_nxt.dx_req = 1'b1;
            st_nxt.dx = {i_isa.write, 1'b1, i_isa.addr, isa_be4, isa_d32};
          end else if (i_isa.write) begin
            if (wr_held && (!hit_tag || (st_r.valid & msk) != 8'h00)) begin
              st_nxt.lbs = LB_FLUSH; // R14 R15
            end else begin
              // Merge; read data still held is dropped first
              st_nxt.valid = (st_r.wr ? st_r.valid : 8'h00) | msk; // R19 R02
              st_nxt.data = (st_r.data & ~bit_mask(msk)) | ({48'h0, i_isa.data} << {i_isa.addr[2:1], 4'h0});
              st_nxt.tag = i_isa.addr[31:`PIB_TAG_LSB];
              st_nxt.wr = 1'b1;
              st_nxt.isa_ack = 1'b1;
              if (mode_line == `PIB_MODE_SINGLE) begin
                st_nxt.lbs = LB_FLUSH; // R05
              end
            end
          end else if (wr_held) begin
            st_nxt.lbs = LB_FLUSH; // R14 R15
          end else if (!st_r.wr && hit_tag && (st_r.valid & msk) == msk) begin
            // Hit: hand bytes out and drop them
            rd_hit = 1'b1;
            st_nxt.isa_rdata = 16'(st_r.data >> {i_isa.addr[2:1], 4'h0});
            st_nxt.valid = st_r.valid & ~msk; // R20
            st_nxt.isa_ack = 1'b1;
          end else begin
            // Miss: drop line, fetch line or just the asked lanes
            st_nxt.wr = 1'b0; // R19
            st_nxt.valid = 8'h00;
            st_nxt.tag = i_isa.addr[31:`PIB_TAG_LSB];
            st_nxt.one = mode_line == `PIB_MODE_SINGLE;
            st_nxt.fidx = (mode_line == `PIB_MODE_SINGLE) ? i_isa.addr[`PIB_HALF_BIT] : 1'b0;
            st_nxt.dx_req = 1'b1;
            st_nxt.dx = {1'b0, 1'b0, i_isa.addr[31:`PIB_TAG_LSB], st_nxt.fidx, 2'h0,
                         (mode_line == `PIB_MODE_SINGLE) ? isa_be4 : 4'hF, 32'h0}; // R06
            st_nxt.lbs = LB_FETCH;
          end
        end
      end
      LB_FLUSH: begin
        // One half per cycle, then wait for PCI to drain the queue
        if (st_r.valid[3:0] != 4'h0) begin
          push_v = 1'b1; // R14
          push_d = half_xfer(st_r.tag, 1'b0, st_r.valid, st_r.data);
          if (fifo_rdy) begin
            st_nxt.valid[3:0] = 4'h0;
          end
        end else if (st_r.valid[7:4] != 4'h0) begin
          push_v = 1'b1;
          push_d = half_xfer(st_r.tag, 1'b1, st_r.valid, st_r.data);
          if (fifo_rdy) begin
            st_nxt.valid[7:4] = 4'h0;
          end
        end else if (!fifo_out_v) begin
          st_nxt.lbs = LB_IDLE; // R15
          st_nxt.wr = 1'b0;
        end
      end
      LB_FETCH: begin
        if (i_dx_ack) begin
          if (st_r.fidx) begin
            st_nxt.data[63:32] = i_dx_rdata;
            st_nxt.valid[7:4] = st_r.dx.be;
          end else begin
            st_nxt.data[31:0] = i_dx_rdata;
            st_nxt.valid[3:0] = st_r.dx.be;
          end
          if (st_r.one || st_r.fidx) begin
            st_nxt.dx_req = 1'b0;
            st_nxt.lbs = LB_IDLE;
          end else begin
            st_nxt.fidx = 1'b1; // R07
            st_nxt.dx.addr[`PIB_HALF_BIT] = 1'b1;
          end
        end
      end
      LB_IO: begin
        if (i_dx_ack) begin
          st_nxt.dx_req = 1'b0;
          st_nxt.isa_rdata = 16'(i_dx_rdata >> {st_r.dx.addr[`PIB_LANE_LSB], 4'h0});
          st_nxt.isa_ack = 1'b1;
          st_nxt.lbs = LB_IDLE;
        end
      end
      default: begin
        st_nxt.lbs = LB_IDLE;
      end
    endcase
    // Accepted PCI write makes read data stale
    if (ps_wacc && !st_r.wr) begin
      st_nxt.valid = 8'h00; // R18
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= `PIB_RST_STATE;
      st_r.dack <= DACK_W'(`PIB_RST_DACK_N);
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign o_isa_ready = st_r.isa_ack;
  assign o_isa_rdata = st_r.isa_rdata;
  assign o_grant_ok = !st_r.pw_valid; // R22
  assign o_dx_req = st_r.dx_req;
  assign o_dx = st_r.dx;
  assign o_ps_trdy = st_r.trdy;
  assign o_ps_retry = st_r.retry;
  assign o_ps_rdata = st_r.ps_rdata;
  assign o_ic_req = st_r.ic_req;
  assign o_ic = st_r.ic;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  // Release of any acknowledge while write data is held
  sequence dack_drop_s;
    dack_drop && wr_held && st_r.lbs == LB_IDLE;
  endsequence

  // Flush under way for a second cycle
  sequence flush_held_s;
    st_r.lbs == LB_FLUSH ##1 st_r.lbs == LB_FLUSH;
  endsequence

  AST_UNCLAIMED: assert property (o_isa_ready |-> $past(i_isa.decoded)) // R01
    else $error("ISA cycle answered without positive decode");
  AST_IO_BYPASS: assert property (st_r.lbs == LB_IO |-> !push_v && $stable(st_r.wr)) // R03
    else $error("I/O cycle touched the line buffer");
  AST_SINGLE_WR: assert property ((st_r.lbs == LB_IDLE && i_isa_req && i_isa.decoded && i_isa.mem // R05
                                   && i_isa.write && !mode_line && st_nxt.isa_ack)
                                  |=> st_r.lbs == LB_FLUSH)
    else $error("Single mode write not flushed");
  AST_POST_COND: assert property ($rose(st_r.pw_valid) |-> $past(i_post_en && !i_isa_busy && !i_isa_owned)) // R09
    else $error("Write posted while not allowed");
  AST_NO_POST_OWNED: assert property ($past(i_isa_owned) |-> !$rose(st_r.pw_valid)) // R22
    else $error("Write posted while ISA owned");
  AST_FULL_RETRY: assert property (o_ps_trdy |-> !$past(st_r.pw_valid)) // R10
    else $error("PCI cycle accepted with posted data held");
  AST_DIRECT_WAIT: assert property (o_ps_trdy && !st_r.pw_valid |-> $past(i_ic_done)) // R11
    else $error("Unposted write answered before ISA done");
  AST_FLUSH_RETRY: assert property ((lb_busy && i_ps_req && !st_r.ic_req && !st_r.trdy && !st_r.retry) // R17
                                    |=> o_ps_retry)
    else $error("PCI cycle not retried during flush");
  AST_FLUSH_WAIT: assert property (flush_held_s |-> !o_isa_ready) // R15
    else $error("ISA cycle released during flush");
  AST_DACK_FLUSH: assert property (dack_drop_s |=> st_r.lbs == LB_FLUSH) // R16
    else $error("Acknowledge release did not flush");
  AST_BYTE_DROP: assert property (rd_hit |=> (st_r.valid & $past(msk)) == 8'h00 ##1 !o_isa_ready) // R20
    else $error("Read byte still valid after hand out");
  AST_FLUSH_BE: assert property (push_v |-> push_d.be != 4'h0) // R23
    else $error("Flush without valid bytes");
endmodule // pib_bridge

// [rtl/pib_params.svh]
`ifndef PIB_PARAMS_SVH
`define PIB_PARAMS_SVH

// Line buffer size in bytes
`define PIB_LINE_BYTES 8
// Depth of the flush queue toward PCI
`define PIB_FIFO_DEPTH 16
// Number of DMA acknowledge lines watched
`define PIB_DACK_W 7
// Line buffer mode encodings
`define PIB_MODE_SINGLE 1'b0
`define PIB_MODE_LINE 1'b1
// Reset value of all block state except the acknowledge copy, which loads PIB_RST_DACK_N
`define PIB_RST_STATE '0
// Idle level of the active low acknowledge lines
`define PIB_RST_DACK_N 7'h7F
// Field positions inside the line
`define PIB_LANE_LSB 1
`define PIB_HALF_BIT 2
`define PIB_TAG_LSB 3

`endif

// [rtl/pib_pkg.sv]
package pib_pkg;

  // Line buffer sequencer states
  typedef enum logic [1:0] {LB_IDLE, LB_FLUSH, LB_FETCH, LB_IO} pib_lb_state_type;

  // Cycle from an ISA master or the DMA
  typedef struct packed {
    logic mem;
    logic write;
    logic dma;
    logic decoded;
    logic [31:0] addr;
    logic [1:0] be;
    logic [15:0] data;
  } pib_isa_req_type;

  // Cycle from a PCI master aimed at the bridge or ISA
  typedef struct packed {
    logic mem;
    logic write;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] data;
  } pib_ps_req_type;

  // One dword transfer on either bus
  typedef struct packed {
    logic write;
    logic io;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] data;
  } pib_xfer_type;

endpackage

// [tb/pib_far_model.sv]
`timescale 1ns/1ps
// Far side: PCI target for flushes and fetches, ISA target for forwarded cycles
module pib_far_model (
  // Clock, reset and pacing
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_slow,
  // Flush write sink
  input wire logic i_pm_valid,
  output logic o_pm_ready,
  // Direct PCI target
  input wire logic i_dx_req,
  input wire pib_pkg::pib_xfer_type i_dx,
  output logic o_dx_ack,
  output logic [31:0] o_dx_rdata,
  // ISA target
  input wire logic i_ic_req,
  input wire pib_pkg::pib_xfer_type i_ic,
  output logic o_ic_done,
  output logic [31:0] o_ic_rdata
);
  import pib_pkg::*;
  logic [3:0] dcnt_r; // Wait states of the PCI target
  logic [3:0] icnt_r; // Wait states of the ISA target
  logic tog_r; // Alternating stall of the flush sink
  logic [3:0] lim; // Wait before each answer
  assign lim = i_slow ? 4'h6 : 4'h1;
  // Slow mode takes a flush only every other cycle
  assign o_pm_ready = i_pm_valid & (~i_slow | tog_r);
  // Data is a scramble of the dword address, so a wrong lane shows
  function automatic logic [31:0] img(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'hC3A5_5A3C;
  endfunction
  // One answer per request; idle data toggles so stale values never match
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {dcnt_r, icnt_r, tog_r, o_dx_ack, o_ic_done} <= '0;
      o_dx_rdata <= 32'h0;
      o_ic_rdata <= 32'h0;
    end else begin
      tog_r <= ~tog_r;
      o_dx_ack <= i_dx_req && !o_dx_ack && dcnt_r == lim;
      dcnt_r <= (i_dx_req && !o_dx_ack && dcnt_r != lim) ? dcnt_r + 4'h1 : 4'h0;
      o_dx_rdata <= (i_dx_req && !o_dx_ack && dcnt_r == lim) ? img(i_dx.addr) : ~o_dx_rdata;
      o_ic_done <= i_ic_req && !o_ic_done && icnt_r == lim;
      icnt_r <= (i_ic_req && !o_ic_done && icnt_r != lim) ? icnt_r + 4'h1 : 4'h0;
      o_ic_rdata <= (i_ic_req && !o_ic_done && icnt_r == lim) ? img(i_ic.addr) : ~o_ic_rdata;
    end
  end
endmodule // pib_far_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import pib_pkg::*;
  logic i_clock, i_nrst, mode_isa, mode_dma, post_en, isa_req, isa_busy, isa_owned, ps_req, slow;
  logic [6:0] dack_n; // Acknowledges, idle high
  pib_isa_req_type isa_in; // ISA cycle fields
  pib_ps_req_type ps_in; // PCI cycle fields
  logic isa_ready, grant_ok, pm_valid, pm_ready, dx_req, dx_ack, ps_trdy, ps_retry, ic_req, ic_done;
  logic [15:0] isa_rdata;
  logic [31:0] dx_rdata, ps_rdata, ic_rdata, rnd, rd, a;
  pib_xfer_type pm, dx, ic, last_dx, e;
  pib_xfer_type pmq[$]; // Flush writes taken by PCI
  int n_fail = 0;
  int num_checks = 0;
  int n_dx = 0; // Direct PCI transfers answered, fetches and I/O
  int n0;
  logic ok, t, r, seen_done;
  logic [15:0] d16;
  pib_bridge i_pib_bridge (.i_clock(i_clock), .i_nrst(i_nrst), .i_mode_isa(mode_isa), .i_mode_dma(mode_dma),
    .i_post_en(post_en), .i_isa_req(isa_req), .i_isa(isa_in), .o_isa_ready(isa_ready), .o_isa_rdata(isa_rdata),
    .i_dack_n(dack_n), .i_isa_busy(isa_busy), .i_isa_owned(isa_owned), .o_grant_ok(grant_ok),
    .o_pm_valid(pm_valid), .o_pm(pm), .i_pm_ready(pm_ready), .o_dx_req(dx_req), .o_dx(dx), .i_dx_ack(dx_ack),
    .i_dx_rdata(dx_rdata), .i_ps_req(ps_req), .i_ps(ps_in), .o_ps_trdy(ps_trdy), .o_ps_retry(ps_retry),
    .o_ps_rdata(ps_rdata), .o_ic_req(ic_req), .o_ic(ic), .i_ic_done(ic_done), .i_ic_rdata(ic_rdata));
  pib_far_model i_pib_far_model (.i_clock(i_clock), .i_rst_n(i_nrst), .i_slow(slow), .i_pm_valid(pm_valid),
    .o_pm_ready(pm_ready), .i_dx_req(dx_req), .i_dx(dx), .o_dx_ack(dx_ack), .o_dx_rdata(dx_rdata),
    .i_ic_req(ic_req), .i_ic(ic), .o_ic_done(ic_done), .o_ic_rdata(ic_rdata));
  // Clock at 25 MHz
  initial begin
    i_clock = 0;
    forever #20 i_clock = ~i_clock;
  end
  // Watch the far side interfaces
  always @(posedge i_clock) begin
    if (pm_valid && pm_ready) pmq.push_back(pm);
    if (dx_req && dx_ack) begin
      n_dx++;
      last_dx = dx;
    end
    if (ic_done) seen_done = 1;
  end
  // Same scramble as the far side holds
  function automatic logic [31:0] img(input logic [31:0] x);
    return {x[31:2], 2'b00} ^ 32'hC3A5_5A3C;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk(name, {31'h0, exp}, {31'h0, got});
  endtask
  // One ISA cycle, held until ready or until the limit runs out
  task automatic isa(input logic m, w, dm, dec, input logic [31:0] ad, input logic [1:0] b, input logic [15:0] wd,
    input int lim, output logic k, output logic [15:0] q);
    k = 0;
    q = '0;
    @(negedge i_clock);
    isa_req = 1;
    isa_in = '{m, w, dm, dec, ad, b, wd};
    for (int i = 0; i < lim && !k; i++) begin
      @(posedge i_clock);
      #1;
      if (isa_ready === 1'b1) begin
        k = 1;
        q = isa_rdata;
      end
    end
    @(negedge i_clock);
    isa_req = 0;
  endtask
  // One PCI cycle, held until target ready or retry
  task automatic ps(input logic m, w, input logic [31:0] ad, d, output logic tr, rt, output logic [31:0] q);
    tr = 0;
    rt = 0;
    @(negedge i_clock);
    ps_req = 1;
    ps_in = '{m, w, ad, 4'hF, d};
    for (int i = 0; i < 80 && !(tr | rt); i++) begin
      @(posedge i_clock);
      #1;
      tr = ps_trdy;
      rt = ps_retry;
      q = ps_rdata;
    end
    @(negedge i_clock);
    ps_req = 0;
  endtask
  task automatic wait_free();
    for (int i = 0; i < 100 && (ic_req !== 1'b0 || grant_ok !== 1'b1); i++) @(posedge i_clock);
    @(negedge i_clock);
    chk_bit("bus_free", 1, ic_req === 1'b0 && grant_ok === 1'b1);
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #800000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {i_nrst, mode_isa, mode_dma, post_en, isa_req, isa_busy, isa_owned, ps_req, seen_done} = '0;
    slow = 1;
    dack_n = 7'h7F;
    isa_in = '0;
    ps_in = '0;
    rnd = 32'h8BB5CB92;
    repeat (5) @(negedge i_clock);
    i_nrst = 1;
    repeat (3) @(negedge i_clock);
    chk_bit("grant_ok", 1, grant_ok);
    // Posted writes, then a cycle while the data is still held
    post_en = 1;
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      a = {8'h00, rnd[23:2], 2'b00};
      ps(1, 1, a, rnd, t, r, rd);
      chk_bit("post_trdy", 1, t);
      chk("ic_addr", a, ic.addr);
      chk("ic_data", rnd, ic.data);
      chk_bit("grant_busy", 0, grant_ok);
      ps(1, k[0], a, 32'h0, t, r, rd);
      chk_bit("retry_held", 1, r);
      wait_free();
    end
    // Owned or busy ISA refuses the write
    isa_owned = 1;
    ps(1, 1, a, 32'h0, t, r, rd);
    chk_bit("retry_owned", 1, r);
    isa_owned = 0;
    post_en = 0;
    isa_busy = 1;
    ps(1, 1, a, 32'h0, t, r, rd);
    chk_bit("retry_busy", 1, r);
    isa_busy = 0;
    // Forwarded write completes only after the ISA cycle
    seen_done = 0;
    ps(1, 1, a, 32'h5, t, r, rd);
    chk_bit("fwd_done", 1, seen_done & t);
    wait_free();
    // Reads and I/O writes bypass posting
    post_en = 1;
    ps(1, 0, a, 32'h0, t, r, rd);
    chk("ps_rdata", img(a), rd);
    seen_done = 0;
    ps(0, 1, 32'h80, 32'h7, t, r, rd);
    chk_bit("io_fwd", 1, seen_done & t);
    wait_free();
    // Undecoded ISA cycle is never answered
    n0 = n_dx;
    isa(1, 0, 0, 0, 32'h100, 2'b11, 16'h0, 20, ok, d16);
    chk("undecoded", {31'h0, 1'b0}, {n_dx - n0, ok});
    // ISA I/O goes straight through
    isa(0, 0, 0, 1, 32'h3F2, 2'b11, 16'h0, 60, ok, d16);
    chk("io_rdata", img(32'h3F0) >> 16, {16'h0, d16});
    chk_bit("io_kind", 1, last_dx.io);
    // Line mode read: two fetches, hit, consumed byte misses
    mode_dma = 1;
    a = 32'h0001_0000;
    n0 = n_dx;
    isa(1, 0, 1, 1, a, 2'b11, 16'h0, 80, ok, d16);
    chk("line_rd", img(a) & 32'hFFFF, {16'h0, d16});
    chk("fetches", 2, n_dx - n0);
    isa(1, 0, 1, 1, a + 6, 2'b11, 16'h0, 80, ok, d16);
    chk("hit_rd", img(a + 4) >> 16, {16'h0, d16});
    chk("hit_fetch", 2, n_dx - n0);
    isa(1, 0, 1, 1, a, 2'b11, 16'h0, 80, ok, d16);
    chk("reread", 4, n_dx - n0);
    ps(1, 1, 32'h50, 32'h1, t, r, rd);
    wait_free();
    isa(1, 0, 1, 1, a + 2, 2'b11, 16'h0, 80, ok, d16);
    chk("inval_pci", 6, n_dx - n0);
    // Single mode read takes only the asked lanes
    isa(1, 0, 0, 1, 32'h2_0002, 2'b10, 16'h0, 80, ok, d16);
    chk("single_be", 4'b1000, last_dx.be);
    // Line mode writes flushed by a read; PCI refused meanwhile
    mode_isa = 1;
    a = 32'h0003_0000;
    pmq.delete();
    isa(1, 1, 0, 1, a, 2'b11, 16'h1234, 20, ok, d16);
    isa(1, 1, 0, 1, a + 4, 2'b01, 16'h00AB, 20, ok, d16);
    fork
      begin
        isa(1, 0, 0, 1, a + 32, 2'b11, 16'h0, 200, ok, d16);
        chk("flush_first", 2, pmq.size());
      end
      begin
        for (int i = 0; i < 50 && pm_valid !== 1'b1; i++) @(posedge i_clock);
        ps(1, 0, 32'h60, 32'h0, t, r, rd);
        chk_bit("retry_flush", 1, r);
      end
    join
    e = pmq.pop_front();
    chk("h0", {a, 4'b0011, 16'h1234}, {e.addr, e.be, e.data[15:0]});
    e = pmq.pop_front();
    chk("h1", {a + 4, 4'b0001, 8'hAB}, {e.addr, e.be, e.data[7:0]});
    // Acknowledge release flushes the write line
    isa(1, 1, 1, 1, a + 64, 2'b11, 16'hBEEF, 20, ok, d16);
    @(negedge i_clock);
    dack_n[0] = 0;
    @(negedge i_clock);
    dack_n[0] = 1;
    for (int i = 0; i < 60 && pmq.size() == 0; i++) @(posedge i_clock);
    chk("dack_flush", 1, pmq.size());
    pmq.delete();
    // Single mode write posts at once with one lane
    mode_isa = 0;
    isa(1, 1, 0, 1, 32'h4_0002, 2'b10, 16'h5A00, 20, ok, d16);
    chk_bit("single_wr", 1, ok);
    for (int i = 0; i < 60 && pmq.size() == 0; i++) @(posedge i_clock);
    e = pmq.pop_front();
    chk("single_pm", {32'h4_0000, 4'b1000, 8'h5A}, {e.addr, e.be, e.data[31:24]});
    print_verdict();
  end
endmodule // tb
